//--- hw/rxwb_pkg.sv
// Purpose: shared constants and carriers for the receive descriptor write-back block
// Assumes: one channel context, APB register access, 32-bit shared memory words
// Notes:   mode codes are used by both design files, register offsets by the top only
package rxwb_pkg;

    // Channel modes
    typedef enum logic [2:0] {
        RXWB_HDLC = 3'b000,
        RXWB_TMA  = 3'b001,
        RXWB_TMB  = 3'b010,
        RXWB_TMR  = 3'b011,
        RXWB_V110 = 3'b100
    } rxwb_mode_e;

    // Register offsets (byte addresses)
    localparam logic [7:0] RXWB_OFS_CTRL  = 8'h00;
    localparam logic [7:0] RXWB_OFS_FIRST = 8'h04;
    localparam logic [7:0] RXWB_OFS_SLOT  = 8'h08;
    localparam logic [7:0] RXWB_OFS_LAST  = 8'h0C;
    localparam logic [7:0] RXWB_OFS_COUNT = 8'h10;

    // Control register fields
    localparam int RXWB_CTRL_MODE_LSB = 0;
    localparam int RXWB_CTRL_CS_BIT   = 3;
    localparam int RXWB_CTRL_C32_BIT  = 4;
    localparam int RXWB_CTRL_MFL_LSB  = 16;
    localparam logic [31:0] RXWB_CTRL_RST = 32'h0104_0000;

    // Status byte bit positions
    localparam int RXWB_ST_OVR   = 0;
    localparam int RXWB_ST_ABORT = 1;
    localparam int RXWB_ST_LONG  = 2;
    localparam int RXWB_ST_NOCT  = 3;
    localparam int RXWB_ST_CRC   = 4;
    localparam int RXWB_ST_SYNC  = 5;
    localparam int RXWB_ST_SHORT = 6;

    // Status values that raise no fault
    localparam logic [7:0] RXWB_ST_CLEAN = 8'h00;
    localparam logic [7:0] RXWB_ST_SHONLY = 8'h40;

    // Short frame limits in bits
    localparam logic [15:0] RXWB_SHORT16 = 16'h0020;
    localparam logic [15:0] RXWB_SHORT32 = 16'h0030;

    // Descriptor geometry: four words, device writes the second only
    localparam int          RXWB_DESC_WORDS = 4;
    localparam logic [31:0] RXWB_WORD2_OFS  = 32'h0000_0004;
    localparam int          RXWB_W2_FE      = 31;
    localparam int          RXWB_W2_DONE    = 30;
    localparam int          RXWB_W2_TALLY   = 16;
    localparam int          RXWB_W2_STATUS  = 8;

    // One completion as reported by the receive datapath
    typedef struct packed {
        logic        frame_end;     // Frame ended in this section
        logic        sync_bad3;     // Three frames with bad sync pattern
        logic        rb_fail;       // internal_rx_buffer inaccessible
        logic        buffer_lost;   // internal_rx_buffer overflowed
        logic        abort_pattern; // Ended by 7F abort flag
        logic        abort_cmd;     // Receive abort command
        logic        fast_abort;    // Fast receive abort command
        logic        hold_seen;     // HOLD bit in current descriptor
        logic        crc_bad;       // Frame check failed
        logic        redirect;      // Jump, fast abort or init command
        logic        init_cmd;      // Receive initialize: no write-back
        logic [15:0] frame_bits;    // Bits between opening and closing flag
        logic [12:0] byte_tally;    // Bytes stored in this section
        logic [31:0] next_ptr;      // Next descriptor pointer from memory
    } rxwb_cmp_s;

    // Memory write toward shared memory
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } rxwb_mem_s;

endpackage : rxwb_pkg

//--- hw/rxwb_status_build.sv
// Purpose: build the status byte and the fault decision of one completion
// Assumes: inputs stable while the caller samples the outputs
// Notes:   purely combinational
`timescale 1ns/1ns
module rxwb_status_build
    import rxwb_pkg::*;
(
    input  wire rxwb_mode_e  mode,       // Channel mode
    input  wire logic        cs_sel,     // checksum_select
    input  wire logic        crc32,      // 32-bit frame check in use
    input  wire logic [15:0] max_len,    // max_frame_length in bits
    input  wire rxwb_cmp_s   cmp,        // Completion causes
    output logic      [7:0]  status,     // Masked status byte
    output logic             fault       // Fault interrupt wanted
);

    logic [7:0] raw;
    logic [7:0] keep;
    logic       long_f;
    logic       hdlc;

    // Every applicable cause sets its own bit together
    always_comb begin
        hdlc   = (mode == RXWB_HDLC);
        long_f = (cmp.frame_bits > max_len);
        raw    = 8'h00;
        raw[RXWB_ST_OVR]   = cmp.buffer_lost | cmp.rb_fail;
        raw[RXWB_ST_ABORT] = cmp.fast_abort | cmp.hold_seen |
                             (hdlc & (cmp.abort_pattern | cmp.abort_cmd));
        raw[RXWB_ST_LONG]  = long_f;
        raw[RXWB_ST_NOCT]  = (cmp.frame_bits[2:0] != 3'b000);
        raw[RXWB_ST_CRC]   = cmp.crc_bad;
        raw[RXWB_ST_SYNC]  = cmp.sync_bad3;
        raw[RXWB_ST_SHORT] = crc32 ? (cmp.frame_bits <= RXWB_SHORT32)
                                   : (cmp.frame_bits <= RXWB_SHORT16);
    end

    // Bits a mode cannot report are forced to zero
    always_comb begin
        case (mode)
            RXWB_HDLC: keep = cs_sel ? 8'h1F : 8'h5F;
            RXWB_V110: keep = 8'h23;
            RXWB_TMB,
            RXWB_TMR:  keep = 8'h0F;
            RXWB_TMA:  keep = 8'h02;
            default:   keep = 8'h00;
        endcase
        status = raw & keep;
        fault  = (status != RXWB_ST_CLEAN) && (status != RXWB_ST_SHONLY);
    end

endmodule : rxwb_status_build

//--- hw/rxwb_top.sv
// Purpose: receive descriptor completion write-back with branch to next descriptor
// Assumes: completions arrive on a valid/ready port, memory writes are acked by ready
// Notes:   registers over APB with zero wait states
// How it works
// - Only second descriptor word is written
// - Frame end sets frame_end, done, frame interrupt in HDLC, TMB, TMR
// - V.110 sync loss completes with fault
// - V.110 buffer failure completes with fault
// - Store next pointer, then branch at once
// - Tally holds bytes placed in section
// - Status written always; fault unless 00/40
// - Mode-inapplicable status bits forced to zero
// - short_frame only HDLC, checksum_select zero
// - Short frame: 32 or 48 bit limit
// - Three bad sync frames set sync_lost
// - Failed frame check sets checksum_error
// - Non-octet bit count sets non_octet_length
// - Overlong frame aborted until next flag
// - Abort causes differ for HDLC and others
// - Buffer overflow sets buffer_overrun
// - Non-HDLC abort only by fast abort/HOLD
// - Multiple causes set all their bits
// - Overrun status not changed by later abort-flag frames
// - Redirect commands branch to first pointer
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module rxwb_top
    import rxwb_pkg::*;
#(
    parameter int CNT_W = 16                      // Completion counter width
) (
    input  wire logic        pclk,                // APB and core clock
    input  wire logic        presetn,             // Asynchronous reset, active low
    input  wire logic        psel,                // APB select
    input  wire logic        penable,             // APB enable
    input  wire logic        pwrite,              // APB direction
    input  wire logic [7:0]  paddr,               // APB byte address
    input  wire logic [31:0] pwdata,              // APB write data
    output logic      [31:0] prdata,              // APB read data
    output logic             pready,              // APB ready
    output logic             pslverr,             // APB error on unmapped address
    input  wire logic        cmp_valid,           // Completion offered
    input  wire rxwb_cmp_s   cmp,                 // Completion content
    output logic             cmp_ready,           // Completion taken
    output rxwb_mem_s        mem,                 // Write-back address and data
    output logic             mem_valid,           // Write-back request
    input  wire logic        mem_ready,           // Shared memory took the word
    input  wire logic        bit_valid,           // One received bit counted
    input  wire logic        flag_seen,           // Flag recognised on the line
    output logic             frame_discard,       // Overlong frame being dropped
    output logic             irq_valid,           // Interrupt event pulse
    output logic             irq_frame,           // frame_indication
    output logic             irq_fault            // fault_flag
);

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WRITE  = 2'b01,
        ST_BRANCH = 2'b10
    } rxwb_state_e;

    rxwb_state_e state;
    logic [31:0] ctrl;
    logic [31:0] first_ptr;
    logic [31:0] slot;
    logic [31:0] last_word;
    logic [CNT_W-1:0] done_cnt;
    logic [31:0] next_ptr;
    logic        pend_frame;
    logic        pend_fault;
    logic        ovr_lock;
    logic [15:0] bit_run;
    logic [7:0]  st_byte;
    logic        st_fault;
    logic        fe_mode;
    logic        take;
    logic        drop;
    logic        wr_done;
    logic        apb_wr;
    logic        apb_rd;
    rxwb_mode_e  mode;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == RXWB_OFS_CTRL) || (a == RXWB_OFS_FIRST) || (a == RXWB_OFS_SLOT) ||
                 (a == RXWB_OFS_LAST) || (a == RXWB_OFS_COUNT);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////
    // Status composition

    rxwb_status_build u_status (
        .mode    (mode),
        .cs_sel  (ctrl[RXWB_CTRL_CS_BIT]),
        .crc32   (ctrl[RXWB_CTRL_C32_BIT]),
        .max_len (ctrl[RXWB_CTRL_MFL_LSB +: 16]),
        .cmp     (cmp),
        .status  (st_byte),
        .fault   (st_fault)
    );

    // Mode decode; frame_end only exists in frame-oriented modes
    always_comb begin
        mode    = rxwb_mode_e'(ctrl[RXWB_CTRL_MODE_LSB +: 3]);
        fe_mode = (mode == RXWB_HDLC) || (mode == RXWB_TMB) || (mode == RXWB_TMR);
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data loaded in the setup cycle

    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite && mapped(paddr);
    assign apb_rd = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            case (paddr)
                RXWB_OFS_CTRL:  prdata <= ctrl;
                RXWB_OFS_FIRST: prdata <= first_ptr;
                RXWB_OFS_SLOT:  prdata <= slot;
                RXWB_OFS_LAST:  prdata <= last_word;
                RXWB_OFS_COUNT: prdata <= 32'(done_cnt);
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Unmapped addresses answer with an error in the access phase
    assign pslverr = psel && penable && !mapped(paddr);

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl      <= RXWB_CTRL_RST;
            first_ptr <= 32'h0000_0000;
        end else if (apb_wr) begin
            if (paddr == RXWB_OFS_CTRL)
                ctrl <= pwdata;
            if (paddr == RXWB_OFS_FIRST)
                first_ptr <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overlong guard: drop the rest of a long frame until the next flag

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_run       <= 16'h0000;
            frame_discard <= 1'b0;
        end else if (flag_seen) begin
            bit_run       <= 16'h0000;
            frame_discard <= 1'b0;
        end else if (bit_valid && !frame_discard) begin
            bit_run <= bit_run + 16'h0001;
            if (bit_run >= ctrl[RXWB_CTRL_MFL_LSB +: 16])
                frame_discard <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion acceptance

    assign cmp_ready = (state == ST_IDLE);
    assign take      = cmp_valid && cmp_ready;
    // After an overrun, a plain aborted frame must not overwrite that report
    assign drop      = ovr_lock && !cmp.buffer_lost && cmp.abort_pattern && !cmp.redirect;
    assign wr_done   = mem_valid && mem_ready;

    // Overrun lock holds until a frame ends with no abort flag and no overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_lock <= 1'b0;
        end else if (take) begin
            if (st_byte[RXWB_ST_OVR])
                ovr_lock <= 1'b1;
            else if (cmp.frame_end && !cmp.abort_pattern)
                ovr_lock <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: write second word, then store pointer and branch

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take && !drop)
                        state <= cmp.init_cmd ? ST_BRANCH : ST_WRITE;
                end
                ST_WRITE: begin
                    if (wr_done)
                        state <= ST_BRANCH;
                end
                ST_BRANCH: state <= ST_IDLE;
                default:   state <= ST_IDLE;
            endcase
        end
    end

    // Latch the word to write and where to go next
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem        <= '0;
            next_ptr   <= 32'h0000_0000;
            pend_frame <= 1'b0;
            pend_fault <= 1'b0;
        end else if (take && !drop) begin
            mem.addr <= slot + RXWB_WORD2_OFS;
            mem.data <= '0;
            mem.data[RXWB_W2_FE]   <= cmp.frame_end && fe_mode;
            mem.data[RXWB_W2_DONE] <= 1'b1;
            mem.data[RXWB_W2_TALLY +: 13]  <= cmp.byte_tally;
            mem.data[RXWB_W2_STATUS +: 8]  <= st_byte;
            next_ptr   <= cmp.redirect ? first_ptr : cmp.next_ptr;
            pend_frame <= cmp.frame_end && fe_mode && !cmp.init_cmd;
            pend_fault <= st_fault && !cmp.init_cmd;
        end
    end

    assign mem_valid = (state == ST_WRITE);

    // Descriptor slot and history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot      <= 32'h0000_0000;
            last_word <= 32'h0000_0000;
            done_cnt  <= '0;
        end else if (state == ST_BRANCH) begin
            slot <= next_ptr;
        end else if (wr_done) begin
            last_word <= mem.data;
            done_cnt  <= done_cnt + 1'b1;
        end else if (apb_wr && paddr == RXWB_OFS_SLOT) begin
            slot <= pwdata;
        end
    end

    // Interrupt event goes out when the word has been written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_valid <= 1'b0;
            irq_frame <= 1'b0;
            irq_fault <= 1'b0;
        end else begin
            irq_valid <= wr_done && (pend_frame || pend_fault);
            irq_frame <= wr_done && pend_frame;
            irq_fault <= wr_done && pend_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_word_out;
        mem_valid && mem_ready;
    endsequence

    sequence s_branch(logic [31:0] p);
        ##1 (state == ST_BRANCH) ##1 (slot == p);
    endsequence

    chk_second_word: assert property (@(posedge pclk) disable iff (!presetn)
        mem_valid |-> mem.addr == slot + RXWB_WORD2_OFS)
        else $error("write-back not aimed at second word");

    chk_done_always: assert property (@(posedge pclk) disable iff (!presetn)
        mem_valid |-> mem.data[RXWB_W2_DONE])
        else $error("done bit missing in write-back");

    chk_fe_modes: assert property (@(posedge pclk) disable iff (!presetn)
        mem_valid && !fe_mode |-> !mem.data[RXWB_W2_FE])
        else $error("frame_end set in a stream mode");

    chk_branch_next: assert property (@(posedge pclk) disable iff (!presetn)
        s_word_out |-> s_branch(next_ptr))
        else $error("no branch after write-back");

    chk_fault_irq: assert property (@(posedge pclk) disable iff (!presetn)
        s_word_out |=> irq_fault == ($past(mem.data[15:8]) != RXWB_ST_CLEAN &&
                                     $past(mem.data[15:8]) != RXWB_ST_SHONLY))
        else $error("fault interrupt does not match status");

    chk_tma_mask: assert property (@(posedge pclk) disable iff (!presetn)
        mode == RXWB_TMA |-> (st_byte & 8'hFD) == 8'h00)
        else $error("stream mode reports a foreign bit");

    chk_short_cs1: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[RXWB_CTRL_CS_BIT] |-> !st_byte[RXWB_ST_SHORT])
        else $error("short_frame with checksum_select set");

    chk_abort_other: assert property (@(posedge pclk) disable iff (!presetn)
        mode != RXWB_HDLC && !cmp.fast_abort && !cmp.hold_seen |-> !st_byte[RXWB_ST_ABORT])
        else $error("abort_seen without fast abort or HOLD");

    chk_long_drop: assert property (@(posedge pclk) disable iff (!presetn)
        frame_discard && !flag_seen |=> frame_discard)
        else $error("overlong drop ended before a flag");

    chk_redirect: assert property (@(posedge pclk) disable iff (!presetn)
        take && !drop && cmp.redirect |=> next_ptr == $past(first_ptr))
        else $error("redirect did not use first pointer");

    sequence s_take_word;
        take && !drop && !cmp.init_cmd;
    endsequence

    chk_hdlc_mask: assert property (
        @(posedge pclk)
        disable iff (!presetn)
        mode == RXWB_HDLC
        |-> !st_byte[RXWB_ST_SYNC])
        else $error("sync_lost in HDLC");

    chk_tally_copy: assert property (
        @(posedge pclk)
        disable iff (!presetn)
        s_take_word |=> mem.data[RXWB_W2_TALLY +: 13]
        == $past(cmp.byte_tally))
        else $error("tally not copied");

    chk_word_next: assert property (
        @(posedge pclk)
        disable iff (!presetn)
        s_take_word
        |=> mem_valid)
        else $error("no write-back");

    chk_init_quiet: assert property (
        @(posedge pclk)
        disable iff (!presetn)
        take && cmp.init_cmd
        |=> !mem_valid)
        else $error("init wrote a word");

    chk_next_ptr: assert property (
        @(posedge pclk)
        disable iff (!presetn)
        take && !drop && !cmp.redirect
        |=> next_ptr == $past(cmp.next_ptr))
        else $error("next pointer lost");

endmodule : rxwb_top

//--- dv/rxwb_shmem_model.sv
// Purpose: shared memory side of the descriptor write-back port
// Assumes: one word per request, stall length set by the bench
// Notes:   ready is low outside requests so a stuck valid is not hidden
`timescale 1ns/1ns
module rxwb_shmem_model
    import rxwb_pkg::*;
(
    input  wire logic       pclk,      // Core clock
    input  wire logic       presetn,   // Reset, active low
    input  wire rxwb_mem_s  mem,       // Write word, checked by the bench
    input  wire logic       mem_valid, // Write request
    input  wire logic [1:0] stall,     // Wait cycles before taking a word
    output logic            mem_ready  // Word taken
);
    logic [1:0] wait_cnt;

    // One ready pulse per word after the stall; reload the stall between words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ready <= 1'h0;
            wait_cnt  <= 2'h0;
        end else if (mem_ready || !mem_valid) begin
            mem_ready <= 1'h0;
            wait_cnt  <= stall;
        end else if (wait_cnt == 2'h0) begin
            mem_ready <= 1'h1;
        end else begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule : rxwb_shmem_model

//--- dv/rxwb_top_test.sv
// Purpose: self-checking bench for the receive descriptor write-back block
// Assumes: zero-wait APB, memory stalls 0..3 cycles
// Notes:   expected words and interrupts are queued by the driver, popped by a watcher
`timescale 1ns/1ns
module rxwb_top_test
    import rxwb_pkg::*;
;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        cmp_valid = 1'h0, bit_valid = 1'h0, flag_seen = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, first, slot;
    logic        pready, pslverr, cmp_ready, mem_valid, mem_ready, frame_discard, irq_valid, irq_frame, irq_fault;
    rxwb_cmp_s   cmp = '0;
    rxwb_mem_s   mem;
    logic [1:0]  stall = 2'h0;
    logic [63:0] mq[$];
    logic [1:0]  iq[$];
    int          n_mismatch = 0, tests_run = 0;

    always #2 pclk = ~pclk;

    rxwb_top rxwb_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_valid(cmp_valid), .cmp(cmp), .cmp_ready(cmp_ready), .mem(mem), .mem_valid(mem_valid),
        .mem_ready(mem_ready), .bit_valid(bit_valid), .flag_seen(flag_seen), .frame_discard(frame_discard),
        .irq_valid(irq_valid), .irq_frame(irq_frame), .irq_fault(irq_fault));
    rxwb_shmem_model rxwb_shmem_model_inst (.pclk(pclk), .presetn(presetn), .mem(mem),
        .mem_valid(mem_valid), .stall(stall), .mem_ready(mem_ready));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // APB master: hold the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        r = {pslverr, prdata};
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Status byte worked out from the causes and the mode's permitted bits
    function automatic logic [7:0] exp_st(rxwb_mode_e m, logic cs, logic c32, rxwb_cmp_s c);
        logic [7:0] s;
        s = 8'h00;
        s[1] = c.fast_abort | c.hold_seen;
        if (m == RXWB_HDLC) begin
            s[1] = s[1] | c.abort_pattern | c.abort_cmd;
            s[4] = c.crc_bad;
            s[6] = !cs && c.frame_bits <= (c32 ? 16'h0030 : 16'h0020);
        end
        if (m inside {RXWB_HDLC, RXWB_TMB, RXWB_TMR}) begin
            s[3] = c.frame_bits[2:0] != 3'h0;
            s[2] = c.frame_bits > 16'h0040;
        end
        if (m != RXWB_TMA) s[0] = c.buffer_lost | (m == RXWB_V110 && c.rb_fail);
        if (m == RXWB_V110) s[5] = c.sync_bad3;
        return s;
    endfunction : exp_st

    // Offer one completion; queue the word and interrupt it must produce
    task automatic send(input rxwb_cmp_s c, input rxwb_mode_e m, input logic cs, input logic c32, input logic wr);
        logic [7:0] s;
        logic       fe;
        logic       flt;
        s   = exp_st(m, cs, c32, c);
        fe  = c.frame_end && (m inside {RXWB_HDLC, RXWB_TMB, RXWB_TMR});
        flt = s != 8'h00 && s != 8'h40;
        if (wr) begin
            mq.push_back({slot + 32'h4, fe, 1'h1, 1'h0, c.byte_tally, s, 8'h00});
            if (fe || flt) iq.push_back({fe, flt});
            slot = c.redirect ? first : c.next_ptr;
        end
        @(posedge pclk);
        cmp       <= c;
        cmp_valid <= 1'h1;
        @(posedge pclk);
        while (cmp_ready !== 1'h1) @(posedge pclk);
        cmp_valid <= 1'h0;
        @(posedge pclk);
        while (cmp_ready !== 1'h1) @(posedge pclk);
    endtask : send

    // Feed n counted bits, then let the discard flag settle
    task automatic bits(input int n);
        @(posedge pclk);
        bit_valid <= 1'h1;
        repeat (n) @(posedge pclk);
        bit_valid <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask : bits

    ////////////////////////////////////////////////////////////////////////
    // Watcher: every accepted word and interrupt pulse must match the oldest note
    always @(posedge pclk) begin
        if (presetn && mem_valid && mem_ready)
            chk({mem.addr, mem.data}, mq.size() ? mq.pop_front() : 64'hFFFF_FFFF_FFFF_FFFF);
        if (presetn && irq_valid)
            chk({irq_frame, irq_fault}, iq.size() ? iq.pop_front() : 2'h3);
    end

    // Watchdog sized well above the longest expected run
    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        logic [32:0] r;
        rxwb_cmp_s   c;
        rxwb_mode_e  m;
        logic        cs;
        logic        c32;
        void'($urandom(30));
        first = 32'h0000_1000;
        slot  = 32'h0000_2000;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        // Reset values, unmapped address, read-only last-word register
        for (int i = 0; i < 5; i++) begin
            apb(1'h0, 8'(i * 4), 32'h0, r);
            chk(r, i == 0 ? {1'h0, RXWB_CTRL_RST} : 33'h0);
        end
        apb(1'h0, 8'h14, 32'h0, r);
        chk(r, 33'h1_0000_0000);
        apb(1'h1, RXWB_OFS_LAST, 32'hFFFF_FFFF, r);
        apb(1'h0, RXWB_OFS_LAST, 32'h0, r);
        chk(r, 33'h0);
        apb(1'h1, RXWB_OFS_FIRST, first, r);
        apb(1'h1, RXWB_OFS_SLOT, slot, r);
        // Random completions in every mode, MAX_FRAME_LENGTH 64, memory stalling at random
        for (int k = 0; k < 150; k++) begin
            m   = rxwb_mode_e'(k / 30);
            cs  = 1'($urandom_range(0, 1));
            c32 = 1'($urandom_range(0, 1));
            apb(1'h1, RXWB_OFS_CTRL, {16'h0040, 11'h000, c32, cs, m}, r);
            c = '0;
            c.frame_end   = (m inside {RXWB_HDLC, RXWB_TMB, RXWB_TMR}) || $urandom_range(0, 1);
            c.sync_bad3   = $urandom_range(0, 3) == 0;
            c.rb_fail     = m == RXWB_V110 && $urandom_range(0, 3) == 0;
            c.buffer_lost = $urandom_range(0, 3) == 0;
            c.abort_cmd   = $urandom_range(0, 3) == 0;
            c.fast_abort  = $urandom_range(0, 7) == 0;
            c.hold_seen   = $urandom_range(0, 7) == 0;
            c.crc_bad     = $urandom_range(0, 3) == 0;
            c.redirect    = c.fast_abort || $urandom_range(0, 7) == 0;
            c.frame_bits  = 16'($urandom_range(0, 80));
            c.byte_tally  = 13'($urandom);
            c.next_ptr    = $urandom & 32'hFFFF_FFF0;
            stall <= 2'($urandom);
            send(c, m, cs, c32, 1'h1);
            apb(1'h0, RXWB_OFS_SLOT, 32'h0, r);
            chk(r, {1'h0, slot});
        end
        // Overrun then an aborted frame: the abort must not produce a new status
        apb(1'h1, RXWB_OFS_CTRL, 32'h0040_0008, r);
        c = '0;
        c.frame_end   = 1'h1;
        c.frame_bits  = 16'h0040;
        c.buffer_lost = 1'h1;
        c.next_ptr    = 32'h0000_3000;
        send(c, RXWB_HDLC, 1'h1, 1'h0, 1'h1);
        c.buffer_lost   = 1'h0;
        c.abort_pattern = 1'h1;
        send(c, RXWB_HDLC, 1'h1, 1'h0, 1'h0);
        c.abort_pattern = 1'h0;
        c.next_ptr      = 32'h0000_5000;
        send(c, RXWB_HDLC, 1'h1, 1'h0, 1'h1);
        // Initialise: branch to the first pointer without a write-back
        c.init_cmd = 1'h1;
        c.redirect = 1'h1;
        send(c, RXWB_HDLC, 1'h1, 1'h0, 1'h0);
        slot = first;
        apb(1'h0, RXWB_OFS_SLOT, 32'h0, r);
        chk(r, {1'h0, slot});
        // Abort flag
        c.init_cmd = 1'h0;
        c.redirect = 1'h0;
        c.abort_pattern = 1'h1;
        send(c, RXWB_HDLC, 1'h1, 1'h0, 1'h1);
        // Overlong: 20 bits allowed, the 21st trips the discard, a flag clears it
        apb(1'h1, RXWB_OFS_CTRL, 32'h0014_0000, r);
        bits(20);
        chk(frame_discard, 1'h0);
        bits(2);
        chk(frame_discard, 1'h1);
        @(posedge pclk);
        flag_seen <= 1'h1;
        @(posedge pclk);
        flag_seen <= 1'h0;
        repeat (2) @(posedge pclk);
        chk(frame_discard, 1'h0);
        apb(1'h0, RXWB_OFS_COUNT, 32'h0, r);
        chk(r, 33'h0_0000_0099);
        repeat (20) @(posedge pclk);
        chk(mq.size() + iq.size(), 64'h0);
        end_of_test();
    end
endmodule : rxwb_top_test
